// *** rtl/sbst_tap.sv ***
// boundary-scan test port of the burst memory, oversampled on clk_sys
// assumes tck, tms, tdi arrive asynchronously and tck is far slower than clk_sys;
// ring_i is the pin ring, already in the clk_sys domain
`default_nettype none

// Operation
// R1 - next state from tms at tck rise
// R2 - registers are 3, 1, 32, 107 bits
// R3 - identity word version, part, vendor fields
// R4 - identity word bit 0 reads one
// R5 - part code differs per organisation
// R6 - code 001 selects identity word
// R7 - code 000 captures ring, outputs stay driven
// R8 - host deselects read port for high-z
// R9 - code 010 captures ring, outputs high-z
// R10 - code 100 captures ring, no preload
// R11 - host never loads codes 011, 101; the bench loads both in t_reserved
// R12 - reserved codes select the bypass bit
// R13 - reset and test-logic-reset load identity instruction
// R14 - capture-ir loads 01 in low bits
// R15 - tdo changes on tck fall only
// R16 - five tms-high edges reset the port
module sbst_tap
	import sbst_pkg::*;
#(
	parameter int ORG = 0
) (
	// clock, reset, enable
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic                clk_en,
	// scan pins
	input  wire logic                tck,
	input  wire logic                tms,
	input  wire logic                tdi,
	output logic                     tdo_q,
	output logic                     tdo_oe_q,
	// memory pin ring
	input  wire logic [BS_LEN-1:0]   ring_i,
	output logic                     out_hiz_q
);

	// R5 part code per organisation
	localparam logic [16:0] PART_CODE = (ORG == 0) ? ID_PART_X8 :
		(ORG == 1) ? ID_PART_X18 : ID_PART_X36;
	// R3 fixed identity fields
	localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, PART_CODE, ID_VENDOR, ID_PRESENT};

	typedef struct packed {
		sbst_state_e                    st;
		logic [IR_LEN-1:0]              ir;
		logic [IR_LEN-1:0]              ir_sh;
		logic [BS_LEN-1:0]              bs;
		logic [ID_LEN-1:0]              id;
		logic                           byp;
		logic                           hiz;
		logic [BUF_DEPTH-1:0][1:0]      fifo;
		logic [1:0]                     cnt;
		logic                           tdo;
		logic                           tdo_oe;
		logic [2:0]                     hi_cnt;
	} sbst_tap_s;

	sbst_tap_s q;
	sbst_tap_s d;

	logic tck_rise;
	logic tck_fall;
	logic tms_lvl;
	logic tdi_lvl;
	logic take;

	// pins, all three delayed alike so tms and tdi stay aligned to tck
	sbst_sync u_sync_tck (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_i   (tck),
		.level_q (),
		.rise_q  (tck_rise),
		.fall_q  (tck_fall)
	);

	sbst_sync u_sync_tms (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_i   (tms),
		.level_q (tms_lvl),
		.rise_q  (),
		.fall_q  ()
	);

	sbst_sync u_sync_tdi (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_i   (tdi),
		.level_q (tdi_lvl),
		.rise_q  (),
		.fall_q  ()
	);

	function automatic sbst_state_e next_st(sbst_state_e s, logic m);
		case (s)
			ST_TLR:   next_st = m ? ST_TLR   : ST_RTI;
			ST_RTI:   next_st = m ? ST_SELDR : ST_RTI;
			ST_SELDR: next_st = m ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: next_st = m ? ST_EX1DR : ST_SHDR;
			ST_SHDR:  next_st = m ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: next_st = m ? ST_UPDR  : ST_PSDR;
			ST_PSDR:  next_st = m ? ST_EX2DR : ST_PSDR;
			ST_EX2DR: next_st = m ? ST_UPDR  : ST_SHDR;
			ST_UPDR:  next_st = m ? ST_SELDR : ST_RTI;
			ST_SELIR: next_st = m ? ST_TLR   : ST_CAPIR;
			ST_CAPIR: next_st = m ? ST_EX1IR : ST_SHIR;
			ST_SHIR:  next_st = m ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: next_st = m ? ST_UPIR  : ST_PSIR;
			ST_PSIR:  next_st = m ? ST_EX2IR : ST_PSIR;
			ST_EX2IR: next_st = m ? ST_UPIR  : ST_SHIR;
			ST_UPIR:  next_st = m ? ST_SELDR : ST_RTI;
			default:  next_st = ST_TLR;
		endcase
	endfunction : next_st

	function automatic sbst_sel_e sel_of(logic [IR_LEN-1:0] ir);
		case (ir)
			// R7 R9 R10 ring capture codes
			IR_EXTEST, IR_SAMPZ, IR_SAMPLE: sel_of = SEL_BS;
			// R6 identity read
			IR_IDCODE: sel_of = SEL_ID;
			// R12 reserved codes fall back to bypass
			default:   sel_of = SEL_BYP;
		endcase
	endfunction : sel_of

	// a tck rise is dropped only if the tdo buffer is full; cannot happen at the
	// rated tck speed since every fall drains one entry
	assign take = tck_rise && (q.cnt != BUF_FULL);

	always_comb begin
		d = q;
		if (take) begin
			case (q.st)
				ST_CAPDR: begin
					case (sel_of(q.ir))
						// R10 ring snapshot, update-dr later has no effect
						SEL_BS:  d.bs = ring_i;
						// R4 identity with presence bit
						SEL_ID:  d.id = ID_WORD;
						default: d.byp = 1'b0;
					endcase
				end
				ST_SHDR: begin
					case (sel_of(q.ir))
						// R2 107-bit chain, msb at tdi
						SEL_BS:  d.bs = {tdi_lvl, q.bs[BS_LEN-1:1]};
						SEL_ID:  d.id = {tdi_lvl, q.id[ID_LEN-1:1]};
						default: d.byp = tdi_lvl;
					endcase
				end
				// R14 fixed capture pattern
				ST_CAPIR: d.ir_sh = IR_CAPTURE;
				ST_SHIR:  d.ir_sh = {tdi_lvl, q.ir_sh[IR_LEN-1:1]};
				ST_UPIR:  d.ir = q.ir_sh;
				default:  d.ir = q.ir;
			endcase
			// R1 state from tms at tck rise
			d.st = next_st(q.st, tms_lvl);
			// R13 identity instruction in reset state
			if (d.st == ST_TLR) begin
				d.ir = IR_RESET;
			end
			// R16 run of tms-high edges
			if (!tms_lvl) begin
				d.hi_cnt = 3'h0;
			end else if (q.hi_cnt != TMS_RESET_EDGES) begin
				d.hi_cnt = q.hi_cnt + 3'h1;
			end
			// R9 only sample-z floats the data outputs; R7 extest leaves them on
			d.hiz = (d.ir == IR_SAMPZ);
			// next tdo bit waits in the buffer for the fall
			d.fifo[q.cnt[0]][1] = (d.st == ST_SHDR) || (d.st == ST_SHIR);
			if (d.st == ST_SHIR) begin
				d.fifo[q.cnt[0]][0] = d.ir_sh[0];
			end else begin
				case (sel_of(d.ir))
					SEL_BS:  d.fifo[q.cnt[0]][0] = d.bs[0];
					SEL_ID:  d.fifo[q.cnt[0]][0] = d.id[0];
					default: d.fifo[q.cnt[0]][0] = d.byp;
				endcase
			end
			d.cnt = q.cnt + 2'h1;
		end
		// R15 tdo moves on the tck fall
		if (tck_fall && q.cnt != 2'h0) begin
			d.tdo_oe  = q.fifo[0][1];
			d.tdo     = q.fifo[0][0];
			d.fifo[0] = q.fifo[1];
			d.cnt     = q.cnt - 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			q    <= '0;
			q.ir <= IR_RESET;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign tdo_q     = q.tdo;
	assign tdo_oe_q  = q.tdo_oe;
	assign out_hiz_q = q.hiz;

	// R1 state moves only on a taken rise
	AST_STATE_ON_RISE: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
		$changed(q.st) && !$past(sys_rst) |-> $past(take && clk_en))
		else $error("state moved without tck rise");

	// R1 low enable freezes every register
	AST_FROZEN: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
		!$past(clk_en) && !$past(sys_rst) |-> $stable(q))
		else $error("state moved while clock enable low");

	// R2 chain shifts by one toward tdo
	AST_BS_SHIFT: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
		$past(q.st == ST_SHDR && sel_of(q.ir) == SEL_BS && take && clk_en)
		|-> q.bs == {$past(tdi_lvl), $past(q.bs[BS_LEN-1:1])})
		else $error("boundary chain shift wrong");

	// R6 identity word shifts toward tdo
	AST_ID_SHIFT: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
		$past(q.st == ST_SHDR && sel_of(q.ir) == SEL_ID && take && clk_en)
		|-> q.id == {$past(tdi_lvl), $past(q.id[ID_LEN-1:1])})
		else $error("identity shift wrong");

	// R12 bypass bit takes tdi in shift-dr
	AST_BYP_SHIFT: assert property (@(posedge clk_sys) disable iff (sys_rst) // R12
		$past(q.st == ST_SHDR && sel_of(q.ir) == SEL_BYP && take && clk_en)
		|-> q.byp == $past(tdi_lvl))
		else $error("bypass shift wrong");

	// R2 instruction loads on leaving update-ir
	AST_IR_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
		$past(q.st == ST_UPIR && take && clk_en) |-> q.ir == $past(q.ir_sh))
		else $error("instruction not loaded from shift stage");

	// R3 fields of a captured identity word
	AST_ID_FIELDS: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
		$past(q.st == ST_CAPDR && q.ir == IR_IDCODE && take && clk_en)
		|-> q.id[ID_LEN-1:ID_VER_LSB] == ID_VERSION && q.id[ID_VEND_LSB+:11] == ID_VENDOR
			&& q.id[ID_PART_LSB+:17] == PART_CODE)
		else $error("identity fields wrong");

	// R4 presence bit
	AST_ID_PRESENT: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
		$past(q.st == ST_CAPDR && q.ir == IR_IDCODE && take && clk_en) |-> q.id[0])
		else $error("identity presence bit low");

	// R10 ring snapshot on capture
	AST_RING_CAP: assert property (@(posedge clk_sys) disable iff (sys_rst) // R10
		$past(q.st == ST_CAPDR && sel_of(q.ir) == SEL_BS && take && clk_en)
		|-> q.bs == $past(ring_i))
		else $error("ring not captured");

	// R9 high-z exactly under sample-z
	AST_HIZ: assert property (@(posedge clk_sys) disable iff (sys_rst) // R9
		q.hiz == (q.ir == IR_SAMPZ))
		else $error("output high-z does not follow instruction");

	// R12 reserved code clears only the bypass bit
	AST_RSVD_BYP: assert property (@(posedge clk_sys) disable iff (sys_rst) // R12
		$past(q.st == ST_CAPDR && q.ir inside {3'h3, 3'h5, 3'h6} && take && clk_en)
		|-> !q.byp && $stable(q.bs) && $stable(q.id))
		else $error("reserved code did not select bypass");

	// R13 identity instruction in reset state
	AST_TLR_IR: assert property (@(posedge clk_sys) disable iff (sys_rst) // R13
		q.st == ST_TLR |-> q.ir == IR_IDCODE)
		else $error("reset state without identity instruction");

	// R14 capture-ir pattern
	AST_CAPIR: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
		$past(q.st == ST_CAPIR && take && clk_en) |-> q.ir_sh[1:0] == 2'h1)
		else $error("capture-ir pattern wrong");

	// R15 tdo only after a fall
	AST_TDO_FALL: assert property (@(posedge clk_sys) disable iff (sys_rst) // R15
		($changed(q.tdo) || $changed(q.tdo_oe)) && !$past(sys_rst) |-> $past(tck_fall && clk_en))
		else $error("tdo changed outside tck fall");

	// R16 five high edges reach reset
	AST_FIVE_TMS: assert property (@(posedge clk_sys) disable iff (sys_rst) // R16
		q.hi_cnt == TMS_RESET_EDGES |-> q.st == ST_TLR)
		else $error("five tms-high edges did not reset");

	COV_SHIFT_IR: cover property (@(posedge clk_sys) disable iff (sys_rst)
		q.st == ST_UPIR ##1 q.ir == IR_SAMPZ);
	COV_ID_OUT: cover property (@(posedge clk_sys) disable iff (sys_rst)
		q.st == ST_SHDR && q.ir == IR_IDCODE && q.tdo_oe);
	COV_RING: cover property (@(posedge clk_sys) disable iff (sys_rst)
		q.st == ST_SHDR && q.ir == IR_SAMPLE);
	COV_BUF_FULL: cover property (@(posedge clk_sys) disable iff (sys_rst)
		q.cnt == BUF_FULL);
	COV_TMS_RESET: cover property (@(posedge clk_sys) disable iff (sys_rst)
		q.hi_cnt == TMS_RESET_EDGES && $past(q.st) == ST_SELIR && q.st == ST_TLR);

endmodule : sbst_tap

`default_nettype wire

// *** common/sbst_pkg.sv ***
// constants and types for the memory boundary-scan test port
// assumes a single system clock that oversamples the scan pins
`default_nettype none

package sbst_pkg;

	// register lengths between tdi and tdo
	localparam int IR_LEN = 3;
	localparam int ID_LEN = 32;
	localparam int BS_LEN = 107;

	// instruction codes
	localparam logic [2:0] IR_EXTEST  = 3'h0;
	localparam logic [2:0] IR_IDCODE  = 3'h1;
	localparam logic [2:0] IR_SAMPZ   = 3'h2;
	localparam logic [2:0] IR_SAMPLE  = 3'h4;
	localparam logic [2:0] IR_BYPASS  = 3'h7;
	localparam logic [2:0] IR_RESET   = IR_IDCODE;
	localparam logic [2:0] IR_CAPTURE = 3'h1;

	// identity word field positions
	localparam int ID_VER_LSB  = 29;
	localparam int ID_PART_LSB = 12;
	localparam int ID_VEND_LSB = 1;

	// identity values: arbitrary, not a real maker or part
	localparam logic [2:0]  ID_VERSION  = 3'h5;
	localparam logic [10:0] ID_VENDOR   = 11'h2B3;
	localparam logic [16:0] ID_PART_X8  = 17'h0A5A1;
	localparam logic [16:0] ID_PART_X18 = 17'h0A5A2;
	localparam logic [16:0] ID_PART_X36 = 17'h0A5A3;
	localparam logic        ID_PRESENT  = 1'h1;

	// pin synchroniser depth and tms reset run
	localparam int         SYNC_STAGES     = 3;
	localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

	// tdo buffer
	localparam int         BUF_DEPTH = 2;
	localparam logic [1:0] BUF_FULL  = 2'h2;

	typedef enum logic [3:0] {
		ST_TLR   = 4'h0,
		ST_RTI   = 4'h1,
		ST_SELDR = 4'h2,
		ST_CAPDR = 4'h3,
		ST_SHDR  = 4'h4,
		ST_EX1DR = 4'h5,
		ST_PSDR  = 4'h6,
		ST_EX2DR = 4'h7,
		ST_UPDR  = 4'h8,
		ST_SELIR = 4'h9,
		ST_CAPIR = 4'hA,
		ST_SHIR  = 4'hB,
		ST_EX1IR = 4'hC,
		ST_PSIR  = 4'hD,
		ST_EX2IR = 4'hE,
		ST_UPIR  = 4'hF
	} sbst_state_e;

	typedef enum logic [1:0] {
		SEL_BS  = 2'h0,
		SEL_ID  = 2'h1,
		SEL_BYP = 2'h2
	} sbst_sel_e;

endpackage : sbst_pkg

`default_nettype wire

// *** rtl/sbst_sync.sv ***
// three-stage pin synchroniser with agreed level and edge pulses
// assumes the pin is asynchronous to clk_sys
`default_nettype none

module sbst_sync
	import sbst_pkg::*;
(
	// clock, reset, enable
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// raw pin
	input  wire logic pin_i,
	// filtered level and one-cycle edges
	output logic      level_q,
	output logic      rise_q,
	output logic      fall_q
);

	typedef struct packed {
		logic [SYNC_STAGES-1:0] stg;
		logic                   lvl;
		logic                   rise;
		logic                   fall;
	} sbst_sync_s;

	sbst_sync_s q;
	sbst_sync_s d;

	always_comb begin
		d      = q;
		d.stg  = {q.stg[1:0], pin_i};
		d.rise = 1'b0;
		d.fall = 1'b0;
		// first stage only feeds the second
		if (q.stg[1] == q.stg[2] && q.stg[2] != q.lvl) begin
			d.lvl  = q.stg[2];
			d.rise = q.stg[2];
			d.fall = ~q.stg[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign level_q = q.lvl;
	assign rise_q  = q.rise;
	assign fall_q  = q.fall;

endmodule : sbst_sync

`default_nettype wire

// *** test/sbst_host.sv ***
// scan controller model: drives tck, tms, tdi at a 160 ns tck period
// assumes a free-running clk_sys; pins move 1 ns after a clk_sys rise
`default_nettype none

module sbst_host (
	// system clock
	input  wire logic clk_sys,
	// scan pins
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo_q,
	input  wire logic tdo_oe_q
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_clk

	// tms settled before rise
	// 40 ns setup and 120 ns hold, well past the oversampling window
	task automatic step(input logic m, input logic d, output logic o, output logic oe, output logic held);
		logic pre;
		tms = m;
		tdi = d;
		wait_clk(10);
		pre = tdo_q;
		tck = 1'b1;
		wait_clk(19);
		held = (pre === tdo_q);
		wait_clk(1);
		tck = 1'b0;
		wait_clk(10);
		o = tdo_q;
		oe = tdo_oe_q;
	endtask : step

	// tdi unused here: toggle it so no stale level looks valid
	task automatic move(input logic m);
		logic o, oe, h;
		step(m, ~tdi, o, oe, h);
	endtask : move

	task automatic tap_reset();
		repeat (5) move(1'b1);
	endtask : tap_reset
endmodule : sbst_host

`default_nettype wire

// *** test/sbst_tap_tb_top.sv ***
// self-checking bench for the boundary-scan port, instance with ORG 0
// assumes the host model drives the pins; clk_en low only in the freeze test
`default_nettype none

module sbst_tap_tb_top
	import sbst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk_sys;
	logic              sys_rst;
	logic              clk_en;
	logic              tck, tms, tdi;
	logic              tdo_x18, tdo_x36;
	logic [ID_LEN-1:0] id_x18, id_x36;
	logic              tdo_q, tdo_oe_q, out_hiz_q;
	logic [BS_LEN-1:0] ring_i;
	int                mismatches;
	int                n_compared;
	int                cycles;

	sbst_tap #(.ORG(0)) i_sbst_tap (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .ring_i(ring_i), .out_hiz_q(out_hiz_q));
	// other organisations share the pins; only their identity words are read
	sbst_tap #(.ORG(1)) i_sbst_tap_x18 (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo_q(tdo_x18), .tdo_oe_q(), .ring_i(ring_i), .out_hiz_q());
	sbst_tap #(.ORG(2)) i_sbst_tap_x36 (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo_q(tdo_x36), .tdo_oe_q(), .ring_i(ring_i), .out_hiz_q());
	sbst_host i_sbst_host (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q),
		.tdo_oe_q(tdo_oe_q));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	// about 22k cycles expected; hang guard well above that
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic chk_vec(input logic [BS_LEN-1:0] got, input logic [BS_LEN-1:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_vec

	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_vec(BS_LEN'(got), BS_LEN'(exp), what);
	endtask : chk_bit

	// from idle: walk to shift, move n bits, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [BS_LEN-1:0] din,
		output logic [BS_LEN-1:0] dout, output logic ok);
		logic o, oe, h;
		dout = '0;
		ok = 1'b1;
		i_sbst_host.move(1'b1);
		if (ir) i_sbst_host.move(1'b1);
		i_sbst_host.move(1'b0);
		for (int i = 0; i <= n; i++) begin
			i_sbst_host.step(i == n, (i == 0) ? 1'b0 : din[i-1], o, oe, h);
			if (i < n) dout[i] = o;
			if (i < ID_LEN) begin
				id_x18[i] = tdo_x18;
				id_x36[i] = tdo_x36;
			end
			ok = ok & h & (oe === (i < n));
		end
		i_sbst_host.move(1'b1);
		i_sbst_host.move(1'b0);
	endtask : scan

	task automatic load_ir(input logic [2:0] code);
		logic [BS_LEN-1:0] d;
		logic ok;
		scan(1'b1, IR_LEN, BS_LEN'(code), d, ok);
		chk_vec(BS_LEN'(d[2:0]), BS_LEN'(IR_CAPTURE), "capture-ir");
		chk_bit(ok, 1'b1, "ir tdo timing");
	endtask : load_ir

	task automatic check_ident();
		logic [BS_LEN-1:0] d;
		logic ok;
		scan(1'b0, ID_LEN, '0, d, ok);
		chk_vec(BS_LEN'(d[31:0]), BS_LEN'({ID_VERSION, ID_PART_X8, ID_VENDOR, ID_PRESENT}), "identity");
		chk_bit(d[0], 1'b1, "presence bit");
		chk_vec(BS_LEN'(id_x18), BS_LEN'({ID_VERSION, ID_PART_X18, ID_VENDOR, ID_PRESENT}), "x18 identity");
		chk_vec(BS_LEN'(id_x36), BS_LEN'({ID_VERSION, ID_PART_X36, ID_VENDOR, ID_PRESENT}), "x36 identity");
		chk_bit(ok, 1'b1, "dr tdo timing");
	endtask : check_ident

	task automatic t_ident();
		i_sbst_host.move(1'b0);
		check_ident();
		chk_bit(out_hiz_q, 1'b0, "hiz after reset");
		$display("test ident done");
	endtask : t_ident

	task automatic t_ring();
		logic [2:0] codes [3] = '{IR_EXTEST, IR_SAMPZ, IR_SAMPLE};
		logic [BS_LEN-1:0] d;
		logic ok;
		foreach (codes[k]) begin
			ring_i = {{52{2'b10}}, codes[k]};
			load_ir(codes[k]);
			chk_bit(out_hiz_q, codes[k] == IR_SAMPZ, "output float");
			scan(1'b0, BS_LEN, ~ring_i, d, ok);
			chk_vec(d, ring_i, "ring capture");
			chk_bit(ok, 1'b1, "ring tdo timing");
		end
		$display("test ring done");
	endtask : t_ring

	// reserved codes loaded on purpose to see the fallback path
	task automatic t_reserved();
		logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, IR_BYPASS};
		logic [BS_LEN-1:0] d;
		logic ok;
		foreach (codes[k]) begin
			load_ir(codes[k]);
			scan(1'b0, 2, BS_LEN'(2'b11), d, ok);
			chk_vec(BS_LEN'(d[1:0]), BS_LEN'(2'b10), "bypass path");
			chk_bit(ok, 1'b1, "bypass tdo timing");
			chk_bit(out_hiz_q, 1'b0, "bypass hiz");
		end
		$display("test reserved done");
	endtask : t_reserved

	task automatic t_tms_reset();
		load_ir(IR_SAMPZ);
		chk_bit(out_hiz_q, 1'b1, "hiz before reset");
		// from shift-dr exactly five highs are needed
		i_sbst_host.move(1'b1);
		i_sbst_host.move(1'b0);
		i_sbst_host.move(1'b0);
		repeat (4) i_sbst_host.move(1'b1);
		chk_bit(out_hiz_q, 1'b1, "hiz after four tms-high");
		i_sbst_host.move(1'b1);
		chk_bit(out_hiz_q, 1'b0, "hiz after tms reset");
		i_sbst_host.move(1'b0);
		check_ident();
		$display("test tms reset done");
	endtask : t_tms_reset

	// a frozen port must ignore a whole reset run on the pins
	task automatic t_freeze();
		load_ir(IR_SAMPZ);
		clk_en = 1'b0;
		i_sbst_host.tap_reset();
		clk_en = 1'b1;
		chk_bit(out_hiz_q, 1'b1, "hiz held while frozen");
		load_ir(IR_SAMPLE);
		chk_bit(out_hiz_q, 1'b0, "hiz after sample");
		$display("test freeze done");
	endtask : t_freeze

	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		ring_i = '0;
		mismatches = 0;
		n_compared = 0;
		cycles = 0;
		repeat (8) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		t_ident();
		t_ring();
		t_reserved();
		t_tms_reset();
		t_freeze();
		conclude();
	end
endmodule : sbst_tap_tb_top

`default_nettype wire
